// *** rtl/i2c_master_pkg.sv ***
// Constants, register map and carrier types for the two-wire master.
// Assumes a 100 MHz system clock and a classic Wishbone slave port.
package i2c_master_pkg;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 10;
    localparam int BIT_PERIOD_NS = 10000;
    localparam int QUARTER_CYC   = BIT_PERIOD_NS / (4 * CLK_PERIOD_NS);
    localparam int FILTER_NS     = 50;
    localparam int FILTER_CYC    = FILTER_NS / CLK_PERIOD_NS;
    localparam logic [8:0] QUARTER_RELOAD = 9'(QUARTER_CYC - 1);
    localparam logic [2:0] FILTER_COUNT   = 3'(FILTER_CYC);

    // ****************************************
    // Register indices (byte address is four times the index)
    // ****************************************
    localparam logic [13:0] DATA_IDX = 14'h0f50;
    localparam logic [13:0] STAT_IDX = 14'h0f51;
    localparam logic [13:0] CTL_IDX  = 14'h0f52;
    localparam logic [7:0]  CTL_RESET = 8'h00;

    // Control bits
    localparam int CTL_ENABLE = 7;
    localparam int CTL_START  = 6;
    localparam int CTL_STOP   = 5;
    localparam int CTL_BAUD   = 4;
    localparam int CTL_TXI    = 3;
    localparam int CTL_NAK    = 2;
    localparam int CTL_FLUSH  = 1;
    localparam int CTL_FILTER = 0;

    // Status bits
    localparam int ST_TX_BUFFER_EMPTY_FLAG = 7;
    localparam int ST_RX_BUFFER_FULL_FLAG = 6;
    localparam int ST_ACK  = 5;
    localparam int ST_TEN  = 4;
    localparam int ST_RD   = 3;
    localparam int ST_TAS  = 2;
    localparam int ST_DSS  = 1;
    localparam int ST_NCK  = 0;

    localparam logic [4:0] TEN_BIT_PREFIX = 5'h1e;

    typedef enum logic [2:0] {
        S_IDLE  = 3'h0,
        S_START = 3'h1,
        S_SHIFT = 3'h3,
        S_ACK   = 3'h2,
        S_HOLD  = 3'h6,
        S_STOP  = 3'h7
    } state_type;

    typedef struct packed {
        logic scl;
        logic sda;
    } link_in_type;

    typedef struct packed {
        logic scl_o;
        logic scl_oe;
        logic sda_o;
        logic sda_oe;
    } link_out_type;

    typedef struct packed {
        state_type       st;
        logic [1:0]      ph;
        logic [8:0]      cnt;
        logic [2:0]      bits;
        logic [7:0]      shf;
        logic [7:0]      data;
        logic [7:0]      ctl;
        logic            tx_buffer_empty_flag;
        logic            rx_buffer_full_flag;
        logic            ack;
        logic            ten;
        logic            rd;
        logic            first;
        logic            addr2;
        logic            nck;
        logic            scl_drv;
        logic            sda_drv;
        logic [1:0]      s1;
        logic [1:0]      s2;
        logic [1:0]      s3;
        logic [1:0]      lvl;
        logic [1:0][2:0] flt;
        logic            wb_ack;
        logic [7:0]      rdat;
        logic            irq;
    } regs_type;

    localparam regs_type REGS_RESET = '0;

endpackage : i2c_master_pkg

// *** rtl/i2c_master_controller.sv ***
// Two-wire bus master with byte shifter, start/stop generation and flags.
// Assumes open-drain pads outside; lines are sampled on the system clock.
//
// Our own choice: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Start bit issues START, then data register moves into the shifter, or a stop follows if it is empty.
// - Transmit interrupt enabled raises interrupt while data register is empty.
// - After a sent byte's first bit shifts out, data register reads empty.
// - Address not acknowledged makes the controller send a stop.
// - Slave holding clock low suspends all bus timing until released.
// - Stop goes out when no byte waits and transmit interrupt is off, or the stop bit is set.
// - Ten-bit first byte is 11110, two top address bits, direction bit.
// - Start set after second ten-bit byte gives a repeated start.
// - Nak control bit answers the next received byte with not-acknowledge.
// - Receive-full flag sets on a byte, interrupts, clears on data read.
// - Ack flag reports acknowledge of the latest byte sent or received.
// - Ten-bit flag sets on prefix 11110 after start, clears after first byte.
// - Read flag takes the data register's low bit as the start condition ends.
// - Address-state flag is high exactly while an address byte shifts.
// - Data-shift flag is high while a data byte shifts.
// - Nack flag sets on nack without start or stop; start/stop clears it.
// - Stop set after a nack interrupt places a stop on the bus.
// - Enable bit gates all operation; control register resets to zero.
module i2c_master_controller (
    // Clock and reset
    input  wire logic                          clk_i,
    input  wire logic                          rst_i,
    // Wishbone slave
    input  wire logic                          wb_cyc_i,
    input  wire logic                          wb_stb_i,
    input  wire logic                          wb_we_i,
    input  wire logic [15:0]                   wb_adr_i,
    input  wire logic [3:0]                    wb_sel_i,
    input  wire logic [31:0]                   wb_dat_i,
    output logic      [31:0]                   wb_dat_o,
    output logic                               wb_ack_o,
    // Serial bus
    input  wire i2c_master_pkg::link_in_type   link_i,
    output i2c_master_pkg::link_out_type       link_o,
    // Interrupt request
    output logic                               irq_o
);
    import i2c_master_pkg::*;

    regs_type    q;
    regs_type    n;
    state_type   nxt;
    logic        jump;
    logic        en;
    logic        tick;
    logic        wait_hi;
    logic        step;
    logic        last;
    logic        tx_dir;
    logic        addr_shift_state;
    logic        data_shift_state;
    logic        req;
    logic        wr_ok;
    logic        set_tx_buffer_empty_flag;
    logic        set_rx_buffer_full_flag;
    logic        set_nck;
    logic        nackd;
    logic [13:0] idx;
    logic [7:0]  stat;

    function automatic logic is_ten(input logic [7:0] b);
        return b[7:3] == TEN_BIT_PREFIX;
    endfunction : is_ten

    // ****************************************
    // Next-state logic
    // ****************************************
    always_comb begin
        n        = q;
        nxt      = q.st;
        jump     = 1'b0;
        en       = q.ctl[CTL_ENABLE];
        tx_dir   = q.first | q.addr2 | ~q.rd;
        addr_shift_state      = (q.st == S_SHIFT) && (q.first || q.addr2);
        data_shift_state      = (q.st == S_SHIFT) && !(q.first || q.addr2);
        tick     = (q.cnt == 9'h000);
        wait_hi  = (q.st == S_START) ? (q.ph == 2'd1)
                 : ((q.st == S_SHIFT || q.st == S_ACK || q.st == S_STOP) && q.ph == 2'd2);
        step     = tick && !(wait_hi && !q.lvl[0]);
        last     = step && (q.ph == 2'd3);
        set_tx_buffer_empty_flag = 1'b0;
        set_rx_buffer_full_flag = 1'b0;
        set_nck  = 1'b0;
        nackd    = 1'b0;
        req      = wb_cyc_i & wb_stb_i & ~q.wb_ack;
        wr_ok    = req & wb_we_i & wb_sel_i[0];
        idx      = wb_adr_i[15:2];
        stat          = 8'h00;
        stat[ST_TX_BUFFER_EMPTY_FLAG] = q.tx_buffer_empty_flag;
        stat[ST_RX_BUFFER_FULL_FLAG] = q.rx_buffer_full_flag;
        stat[ST_ACK]  = q.ack;
        stat[ST_TEN]  = q.ten;
        stat[ST_RD]   = q.rd;
        stat[ST_TAS]  = addr_shift_state;
        stat[ST_DSS]  = data_shift_state;
        stat[ST_NCK]  = q.nck;

        // Three-stage sampling; a change counts once stages two and three agree, with the filter on once they agreed FILTER_COUNT cycles longer
        n.s1 = {link_i.sda, link_i.scl};
        n.s2 = q.s1;
        n.s3 = q.s2;
        for (int i = 0; i < 2; i++) begin
            if (q.s2[i] != q.s3[i] || q.s3[i] == q.lvl[i]) begin
                n.flt[i] = 3'h0;
            end else if (!q.ctl[CTL_FILTER] || q.flt[i] == FILTER_COUNT) begin
                n.lvl[i] = q.s3[i];
                n.flt[i] = 3'h0;
            end else begin
                n.flt[i] = q.flt[i] + 3'h1;
            end
        end

        // Quarter-bit timer; held at its reload value while a released clock line is still held low
        n.cnt = tick ? QUARTER_RELOAD : q.cnt - 9'h001;
        if (wait_hi && !q.lvl[0]) begin
            n.cnt = QUARTER_RELOAD;
        end
        if (step) begin
            n.ph = q.ph + 2'd1;
        end

        // Line drive; in shift and ack, data only changes a phase after the clock falls
        case (q.st)
            S_START: begin
                n.sda_drv = q.ph[1];
                n.scl_drv = (q.ph == 2'd0) ? q.scl_drv : 1'b0;
            end
            S_SHIFT: begin
                n.scl_drv = ~q.ph[1];
                n.sda_drv = (q.ph == 2'd0) ? q.sda_drv : (tx_dir & ~q.shf[7]);
            end
            S_ACK: begin
                n.scl_drv = ~q.ph[1];
                n.sda_drv = (q.ph == 2'd0) ? q.sda_drv : (~tx_dir & ~q.ctl[CTL_NAK]);
            end
            S_HOLD: begin
                n.scl_drv = 1'b1;
                // Release data only once the clock is already low, never a false stop
                n.sda_drv = q.scl_drv ? 1'b0 : q.sda_drv;
            end
            S_STOP: begin
                n.scl_drv = ~q.ph[1];
                n.sda_drv = (q.ph == 2'd0) ? q.sda_drv : (q.ph != 2'd3);
            end
            default: begin
                n.scl_drv = 1'b0;
                n.sda_drv = 1'b0;
            end
        endcase

        // ****************************************
        // Byte sequencer
        // ****************************************
        case (q.st)
            S_IDLE: begin
                if (en && q.ctl[CTL_START]) begin
                    jump = 1'b1;
                    nxt  = S_START;
                end
            end
            S_START: begin
                if (last) begin
                    n.ctl[CTL_START] = 1'b0;
                    jump             = 1'b1;
                    if (q.tx_buffer_empty_flag) begin
                        nxt = S_STOP;
                    end else begin
                        nxt     = S_SHIFT;
                        n.shf   = q.data;
                        n.rd    = q.data[0];
                        n.ten   = is_ten(q.data);
                        n.first = 1'b1;
                        n.addr2 = 1'b0;
                        n.bits  = 3'd7;
                    end
                end
            end
            S_SHIFT: begin
                if (last) begin
                    n.shf  = {q.shf[6:0], tx_dir ? 1'b0 : q.lvl[1]};
                    n.bits = q.bits - 3'd1;
                    if (q.bits == 3'd7 && tx_dir) begin
                        set_tx_buffer_empty_flag = 1'b1;
                    end
                    if (q.bits == 3'd0) begin
                        jump = 1'b1;
                        nxt  = S_ACK;
                    end
                end
            end
            S_ACK: begin
                if (last) begin
                    nackd = tx_dir ? q.lvl[1] : q.ctl[CTL_NAK];
                    n.ack = ~nackd;
                    if (!tx_dir) begin
                        set_rx_buffer_full_flag       = 1'b1;
                        n.ctl[CTL_NAK] = 1'b0;
                    end
                    // Second byte of a ten-bit write is still address
                    n.addr2 = q.first & q.ten & ~q.rd;
                    if (q.first) begin
                        n.ten = 1'b0;
                    end
                    n.first = 1'b0;
                    if (nackd && !q.ctl[CTL_START] && !q.ctl[CTL_STOP]) begin
                        set_nck = 1'b1;
                    end
                    jump = 1'b1;
                    nxt  = (nackd && tx_dir && (q.first || q.addr2)) ? S_STOP : S_HOLD;
                end
            end
            S_HOLD: begin
                if (q.ctl[CTL_STOP]) begin
                    jump = 1'b1;
                    nxt  = S_STOP;
                end else if (q.ctl[CTL_START]) begin
                    jump = 1'b1;
                    nxt  = S_START;
                end else if (q.nck) begin
                    jump = 1'b0;
                end else if (!tx_dir) begin
                    if (!q.rx_buffer_full_flag) begin
                        jump   = 1'b1;
                        nxt    = S_SHIFT;
                        n.bits = 3'd7;
                    end
                end else if (!q.tx_buffer_empty_flag) begin
                    jump   = 1'b1;
                    nxt    = S_SHIFT;
                    n.shf  = q.data;
                    n.bits = 3'd7;
                end else if (!q.ctl[CTL_TXI]) begin
                    jump = 1'b1;
                    nxt  = S_STOP;
                end
            end
            S_STOP: begin
                if (last) begin
                    n.ctl[CTL_STOP] = 1'b0;
                    jump            = 1'b1;
                    nxt             = S_IDLE;
                end
            end
            default: begin
                jump = 1'b1;
                nxt  = S_IDLE;
            end
        endcase
        if (jump) begin
            n.st  = nxt;
            n.ph  = 2'd0;
            n.cnt = QUARTER_RELOAD;
        end
        if (!en) begin
            n.st      = S_IDLE;
            n.ph      = 2'd0;
            n.scl_drv = 1'b0;
            n.sda_drv = 1'b0;
        end

        // ****************************************
        // Register access (one wait state)
        // ****************************************
        n.wb_ack = req;
        if (req) begin
            n.rdat = 8'h00;
            case (idx)
                DATA_IDX: begin
                    n.rdat = q.data;
                    if (wr_ok) begin
                        n.data = wb_dat_i[7:0];
                        n.tx_buffer_empty_flag = 1'b0;
                    end else if (!wb_we_i) begin
                        n.rx_buffer_full_flag = 1'b0;
                    end
                end
                STAT_IDX: n.rdat = stat;
                CTL_IDX: begin
                    n.rdat = q.ctl;
                    if (wr_ok) begin
                        n.ctl            = wb_dat_i[7:0];
                        n.ctl[CTL_FLUSH] = 1'b0;
                        if (wb_dat_i[CTL_FLUSH]) begin
                            n.tx_buffer_empty_flag = 1'b1;
                        end
                        if (wb_dat_i[CTL_START] || wb_dat_i[CTL_STOP]) begin
                            n.nck = 1'b0;
                        end
                        if (wb_dat_i[CTL_START]) begin
                            n.ten = is_ten(q.data);
                        end
                    end
                end
                default: n.rdat = 8'h00;
            endcase
        end

        // Hardware events win over a same-cycle software clear
        if (set_tx_buffer_empty_flag) begin
            n.tx_buffer_empty_flag = 1'b1;
        end
        if (set_rx_buffer_full_flag) begin
            n.rx_buffer_full_flag = 1'b1;
            n.data = q.shf;
        end
        if (set_nck) begin
            n.nck = 1'b1;
        end
        n.irq = en & ((q.ctl[CTL_TXI] & q.tx_buffer_empty_flag) | q.rx_buffer_full_flag | q.nck);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= REGS_RESET;
        end else begin
            q <= n;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign wb_dat_o      = {24'h00_0000, q.rdat};
    assign wb_ack_o      = q.wb_ack;
    assign irq_o         = q.irq;
    assign link_o.scl_o  = 1'b0;
    assign link_o.scl_oe = q.scl_drv;
    assign link_o.sda_o  = 1'b0;
    assign link_o.sda_oe = q.sda_drv;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_start_issue;
        (q.st == S_IDLE && q.ctl[CTL_START] && en) |=> (q.st == S_START);
    endproperty
    a_start_issue: assert property (p_start_issue) else $error("start not issued");

    property p_tx_irq;
        (en && q.ctl[CTL_TXI] && q.tx_buffer_empty_flag) |=> irq_o;
    endproperty
    a_tx_irq: assert property (p_tx_irq) else $error("tx irq missing");

    property p_first_bit;
        (q.st == S_SHIFT && last && q.bits == 3'd7 && tx_dir) |=> q.tx_buffer_empty_flag;
    endproperty
    a_first_bit: assert property (p_first_bit) else $error("tx_buffer_empty_flag not set");

    property p_addr_nack;
        (q.st == S_ACK && last && q.first && tx_dir && q.lvl[1] && en) |=> (q.st == S_STOP);
    endproperty
    a_addr_nack: assert property (p_addr_nack) else $error("no stop on nack");

    property p_stretch;
        (en && wait_hi && !q.lvl[0]) |=> (q.ph == $past(q.ph) && q.cnt == QUARTER_RELOAD);
    endproperty
    a_stretch: assert property (p_stretch) else $error("stretch ignored");

    property p_nak_send;
        (q.st == S_ACK && q.ph == 2'd2 && !tx_dir && q.ctl[CTL_NAK] && en) |=> !q.sda_drv;
    endproperty
    a_nak_send: assert property (p_nak_send) else $error("nak not sent");

    property p_rx_clear;
        (req && !wb_we_i && idx == DATA_IDX && !set_rx_buffer_full_flag) |=> !q.rx_buffer_full_flag;
    endproperty
    a_rx_clear: assert property (p_rx_clear) else $error("rx_buffer_full_flag not cleared");

    property p_nck_clear;
        (wr_ok && idx == CTL_IDX && wb_dat_i[CTL_START] && !set_nck) |=> !q.nck;
    endproperty
    a_nck_clear: assert property (p_nck_clear) else $error("nck not cleared");

endmodule : i2c_master_controller

`default_nettype wire

// *** verif/i2c_slave_model.sv ***
// Behavioural two-wire slave: acks its own address or a ten-bit prefix.
// Assumes resolved open-drain lines with pull-ups, watched on the bench clock.
`timescale 1ns/1ps
`default_nettype none
module i2c_slave_model #(
    parameter logic [6:0] ADDR = 7'h2a
) (
    // Clock and lines
    input  wire logic       clk_i,
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    // Byte served on reads
    input  wire logic [7:0] tx_i,
    // Line drive and observations
    output logic            sda_oe_o,
    output logic            busy_o,
    output logic [7:0]      addr_o,
    output logic [7:0]      rx_o,
    output logic            nack_o
);
    logic [1:0] ln_q = 2'h3;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic       adr_ph;
    logic       rd;
    logic       sel;
    logic       hit;

    // Prefix match stands for any ten-bit slave
    assign hit = sh[7:1] == ADDR || sh[7:3] == 5'h1e;

    initial begin
        sda_oe_o = 1'b0;
        busy_o = 1'b0;
        nack_o = 1'b0;
    end

    // ********
    // Line watcher
    // ********
    always @(posedge clk_i) begin
        ln_q <= {scl_i, sda_i};
        if (ln_q == 2'h3 && {scl_i, sda_i} == 2'h2) begin
            busy_o <= 1'b1;
            cnt <= 4'h0;
            adr_ph <= 1'b1;
            rd <= 1'b0;
            nack_o <= 1'b0;
            sda_oe_o <= 1'b0;
        end else if (ln_q == 2'h2 && {scl_i, sda_i} == 2'h3) begin
            busy_o <= 1'b0;
            sda_oe_o <= 1'b0;
        end else if (busy_o && !ln_q[1] && scl_i) begin
            cnt <= (cnt == 4'h8) ? 4'h0 : cnt + 4'h1;
            if (cnt != 4'h8) sh <= {sh[6:0], sda_i};
            else if (adr_ph) addr_o <= sh;
            else if (rd) nack_o <= sda_i;
            else rx_o <= sh;
            if (cnt == 4'h8) adr_ph <= 1'b0;
        end else if (busy_o && ln_q[1] && !scl_i) begin
            // Drive changes only while clock is low and holds through the high phase
            if (cnt == 4'h8 && adr_ph) begin
                sel <= hit;
                rd <= sh[0] && hit;
                sda_oe_o <= hit;
            end else if (cnt == 4'h8) begin
                sda_oe_o <= sel && !rd;
            end else begin
                sda_oe_o <= rd && !nack_o && !tx_i[3'h7 - cnt[2:0]];
            end
        end
    end
endmodule : i2c_slave_model
`default_nettype wire

// *** verif/i2c_master_controller_test.sv ***
// Self-checking bench: register bus, bus traffic and flags of the master.
// Assumes pull-ups on both lines and the slave model on the far side.
`timescale 1ns/1ps
`default_nettype none
module i2c_master_controller_test;
    import i2c_master_pkg::*;
    localparam logic [6:0] SLV = 7'h2a;
    logic            clk_i;
    logic            rst_i;
    logic            cyc;
    logic            stb;
    logic            we;
    logic [15:0]     adr;
    logic [31:0]     wdat;
    logic [31:0]     wb_dat;
    logic            wb_ack;
    logic            irq;
    logic            scl_hold;
    logic [7:0]      slv_tx;
    logic [7:0]      rdat;
    link_in_type     link_in;
    link_out_type    link_out;
    wire logic       slv_oe;
    wire logic       slv_busy;
    wire logic [7:0] slv_addr;
    wire logic [7:0] slv_rx;
    wire logic       slv_nack;
    int              fails;
    int              total_checks;

    // Pull-ups: a line is low while anyone pulls it
    assign link_in = {~(link_out.scl_oe | scl_hold), ~(link_out.sda_oe | slv_oe)};

    i2c_master_controller i_i2c_master_controller (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(wb_dat),
        .wb_ack_o(wb_ack), .link_i(link_in), .link_o(link_out), .irq_o(irq));

    i2c_slave_model #(.ADDR(SLV)) i_i2c_slave_model (
        .clk_i(clk_i), .scl_i(link_in.scl), .sda_i(link_in.sda), .tx_i(slv_tx),
        .sda_oe_o(slv_oe), .busy_o(slv_busy), .addr_o(slv_addr), .rx_o(slv_rx),
        .nack_o(slv_nack));

    // ********
    // Shared tasks
    // ********
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic final_report;
        if (fails == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : final_report

    task automatic timeout;
        fails++;
        $display("[FAIL] %0t wait ran out", $time);
        final_report;
    endtask : timeout

    task automatic bus(input logic w, input logic [13:0] idx, input logic [7:0] d);
        int   n;
        logic got;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'h0};
        wdat <= 32'(d);
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack !== 1'b1 && n < 20);
        got = wb_ack;
        rdat = wb_dat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
        if (got !== 1'b1) timeout;
    endtask : bus

    task automatic wait_st(input int b, input logic v);
        for (int n = 0; n < 20000; n++) begin
            bus(1'b0, STAT_IDX, 8'h00);
            if (rdat[b] === v) return;
        end
        timeout;
    endtask : wait_st

    task automatic wait_idle;
        for (int n = 0; n < 30000; n++) begin
            @(posedge clk_i);
            if (slv_busy === 1'b0 && link_out === 4'h0) return;
        end
        timeout;
    endtask : wait_idle

    // ********
    // Scenarios
    // ********
    task automatic t_regs;
        bus(1'b0, CTL_IDX, 8'h00);
        check(rdat, CTL_RESET);
        bus(1'b0, STAT_IDX, 8'h00);
        check(rdat, 8'h00);
        bus(1'b0, 14'h0f53, 8'h00);
        check(rdat, 8'h00);
        bus(1'b1, DATA_IDX, 8'h55);
        bus(1'b1, CTL_IDX, 8'h48);
        repeat (2000) @(posedge clk_i);
        check(8'(link_out), 8'h00);
        check(irq, 1'b0);
        bus(1'b1, CTL_IDX, 8'h03);
        bus(1'b0, CTL_IDX, 8'h00);
        check(rdat, 8'h01);
        bus(1'b0, STAT_IDX, 8'h00);
        check(rdat[ST_TX_BUFFER_EMPTY_FLAG], 1'b1);
    endtask : t_regs

    task automatic t_write7;
        bus(1'b1, DATA_IDX, {SLV, 1'b0});
        bus(1'b1, CTL_IDX, 8'hc8);
        wait_st(ST_TAS, 1'b1);
        check(slv_busy, 1'b1);
        wait_st(ST_TX_BUFFER_EMPTY_FLAG, 1'b1);
        check(rdat[ST_TAS], 1'b1);
        check(irq, 1'b1);
        bus(1'b1, DATA_IDX, 8'ha5);
        wait_st(ST_DSS, 1'b1);
        check(rdat[ST_TAS], 1'b0);
        check(rdat[ST_ACK], 1'b1);
        check(slv_addr, {SLV, 1'b0});
        wait_st(ST_TX_BUFFER_EMPTY_FLAG, 1'b1);
        bus(1'b1, CTL_IDX, 8'h80);
        wait_idle;
        check(slv_rx, 8'ha5);
        bus(1'b0, STAT_IDX, 8'h00);
        check(rdat[ST_DSS], 1'b0);
    endtask : t_write7

    task automatic t_nack_addr;
        bus(1'b1, DATA_IDX, 8'h22);
        bus(1'b1, CTL_IDX, 8'hc0);
        wait_st(ST_NCK, 1'b1);
        check(rdat[ST_ACK], 1'b0);
        wait_idle;
        check(slv_addr, 8'h22);
        check(irq, 1'b1);
        bus(1'b1, CTL_IDX, 8'ha0);
        bus(1'b0, STAT_IDX, 8'h00);
        check(rdat[ST_NCK], 1'b0);
        // Let any stop that the write provoked run out
        repeat (200) @(posedge clk_i);
        wait_idle;
    endtask : t_nack_addr

    task automatic t_read7;
        slv_tx <= 8'h3c;
        bus(1'b1, DATA_IDX, {SLV, 1'b1});
        bus(1'b1, CTL_IDX, 8'hc4);
        wait_st(ST_RX_BUFFER_FULL_FLAG, 1'b1);
        check(rdat[ST_RD], 1'b1);
        check(irq, 1'b1);
        bus(1'b0, DATA_IDX, 8'h00);
        check(rdat, 8'h3c);
        wait_st(ST_NCK, 1'b1);
        check(rdat[ST_RX_BUFFER_FULL_FLAG], 1'b0);
        check(rdat[ST_ACK], 1'b0);
        check(slv_nack, 1'b1);
        check(slv_busy, 1'b1);
        bus(1'b1, CTL_IDX, 8'ha0);
        wait_idle;
    endtask : t_read7

    task automatic t_ten;
        int           n;
        int           bad;
        link_out_type lo0;
        bad = 0;
        bus(1'b1, DATA_IDX, 8'hf4);
        // Glitch filter on, so it sees real traffic
        bus(1'b1, CTL_IDX, 8'hc1);
        bus(1'b0, STAT_IDX, 8'h00);
        check(rdat[ST_TEN], 1'b1);
        for (n = 0; n < 5000 && link_out.scl_oe !== 1'b1; n++) @(posedge clk_i);
        if (n == 5000) timeout;
        // Stretch the clock; past the data-setup quarter neither line may move
        scl_hold <= 1'b1;
        repeat (600) @(posedge clk_i);
        lo0 = link_out;
        for (n = 0; n < 1200; n++) begin
            @(posedge clk_i);
            if (link_out !== lo0) bad++;
        end
        check(8'(bad != 0), 8'h00);
        scl_hold <= 1'b0;
        wait_st(ST_TX_BUFFER_EMPTY_FLAG, 1'b1);
        bus(1'b1, DATA_IDX, 8'h55);
        wait_st(ST_TEN, 1'b0);
        check(slv_addr, 8'hf4);
        // Second address byte out; queue the read prefix behind a repeated start
        wait_st(ST_TX_BUFFER_EMPTY_FLAG, 1'b1);
        check(rdat[ST_TAS], 1'b1);
        bus(1'b1, DATA_IDX, 8'hf5);
        bus(1'b1, CTL_IDX, 8'hc5);
        wait_st(ST_RX_BUFFER_FULL_FLAG, 1'b1);
        check(rdat[ST_RD], 1'b1);
        check(slv_addr, 8'hf5);
        check(slv_rx, 8'h55);
        bus(1'b0, DATA_IDX, 8'h00);
        check(rdat, slv_tx);
        bus(1'b1, CTL_IDX, 8'ha1);
        wait_idle;
    endtask : t_ten

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    initial begin
        rst_i = 1'b1;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 16'h0000;
        wdat = 32'h0000_0000;
        scl_hold = 1'b0;
        slv_tx = 8'h00;
        fails = 0;
        total_checks = 0;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs;
        t_write7;
        t_nack_addr;
        t_read7;
        t_ten;
        final_report;
    end
endmodule : i2c_master_controller_test
`default_nettype wire
